// File: design/vic_pkg.sv
// Constants and carrier types of the vectored interrupt controller registers.
// Behaviour
// - PCI reset or software reset returns every controller register to default.
// - Mask registers reset to zero; a zero bit masks its source.
// - Steering registers reset to zero; a zero bit routes the source to IRQ.
// - IRQ source registers reset to zero, no IRQ source active.
// - FIQ source registers reset to zero, no FIQ source active.
// - Eight priority registers, sixteen sources each, all reset to level zero.
// - Every register is 32 bits and also reachable by memory-mapped access.
// - Register select field picks the register inside the group field's group.
// - Group 2 holds base, size, IRQ vector and FIQ vector; others reserved.
// - Group 3 selects 0 to 3 are the four raw pending registers.
// - Group 4 selects 0 to 3 are the four mask registers.
// - Group 5 selects 0 to 3 are the four steering registers.
// - Group 6 selects 0 to 3 are the four IRQ source registers.
// - Group 7 selects 0 to 3 are the four FIQ source registers.
// - Group 8 selects 0 to 7 are the eight priority registers.
// - Group 9 belongs to the timers; the controller never answers it.
// - One routine region for up to 128 sources starts at the base register.
// - Software aligns the base to the region size; hardware uses upper bits only.
// - Region of 512 bytes uses upper 23 base bits, 64 KB uses upper 16.
// - Size code gives spacing 4 bytes to 64 KB; code zero disables the region.
// - Vector is base plus index times spacing of best source, else all ones.
// - Sources are levels; an active bit follows its request without latching.
package vic_pkg;

  localparam int DATA_W = 32;
  localparam int SRC_PER_WORD = 32;
  localparam int SRC_PER_PRIO = 16;
  localparam int PRIO_W = 2;
  localparam int IDX_W = 7;
  localparam int SIZE_W = 4;
  localparam int MAX_SRC = 128;
  localparam int MM_ADDR_W = 10;

  // Group field values.
  localparam logic [3:0] GRP_CTRL = 4'h2;
  localparam logic [3:0] GRP_PEND = 4'h3;
  localparam logic [3:0] GRP_MASK = 4'h4;
  localparam logic [3:0] GRP_ROUTE = 4'h5;
  localparam logic [3:0] GRP_IRQ_ACT = 4'h6;
  localparam logic [3:0] GRP_FIQ_ACT = 4'h7;
  localparam logic [3:0] GRP_PRIO = 4'h8;
  localparam logic [3:0] GRP_TIMER = 4'h9;

  // Register select values inside the control group.
  localparam logic [3:0] SEL_BASE = 4'h0;
  localparam logic [3:0] SEL_SIZE = 4'h2;
  localparam logic [3:0] SEL_IRQ_VEC = 4'h3;
  localparam logic [3:0] SEL_FIQ_VEC = 4'h4;

  // Memory-mapped byte address layout: group in [9:6], select in [5:2].
  localparam int MM_GRP_LSB = 6;
  localparam int MM_SEL_LSB = 2;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [3:0] RST_SIZE = 4'h0;
  localparam logic [31:0] VEC_NONE = 32'hFFFF_FFFF;
  localparam logic [3:0] SIZE_OFF = 4'h0;

  // Spacing is 1 << (code + SPACE_SHIFT); region is 1 << (code + REGION_SHIFT).
  localparam int SPACE_SHIFT = 1;
  localparam int REGION_SHIFT = 8;

  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] grp;
    logic [3:0] sel;
    logic [31:0] wdata;
  } vic_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } vic_rsp_t;

endpackage

// File: design/vic_regs.sv
// Register set, masking, steering, prioritising and vectoring of 128 sources.
`timescale 1ns/1ps
module vic_regs #(
  parameter int NUM_SRC = 128
) (
  // Clock and resets
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic sw_reset_i,
  // Coprocessor register port
  input wire vic_pkg::vic_req_t cp_req_i,
  output vic_pkg::vic_rsp_t cp_rsp_o,
  // Memory-mapped register port
  input wire logic mm_valid_i,
  input wire logic mm_write_i,
  input wire logic [vic_pkg::MM_ADDR_W-1:0] mm_addr_i,
  input wire logic [31:0] mm_wdata_i,
  output vic_pkg::vic_rsp_t mm_rsp_o,
  // Interrupt sources and processor requests
  input wire logic [NUM_SRC-1:0] src_i,
  output logic irq_o,
  output logic fiq_o
);
  import vic_pkg::*;

  localparam int NW = NUM_SRC / SRC_PER_WORD;
  localparam int NP = NUM_SRC / SRC_PER_PRIO;

  if (NUM_SRC < SRC_PER_WORD || NUM_SRC > MAX_SRC ||
      NUM_SRC % SRC_PER_WORD != 0) begin : g_check
    $error("NUM_SRC must be a multiple of 32 between 32 and 128");
  end

  vic_req_t mm_req;
  logic [31:0] mask_q [NW];
  logic [31:0] route_q [NW];
  logic [31:0] prio_q [NP];
  logic [NUM_SRC-1:0] mask_all;
  logic [NUM_SRC-1:0] route_all;
  logic [PRIO_W*NUM_SRC-1:0] prio_all;
  logic [31:0] base_q;
  logic [SIZE_W-1:0] size_q;
  logic [NUM_SRC-1:0] pend_q;
  logic [NUM_SRC-1:0] irq_act_q;
  logic [NUM_SRC-1:0] fiq_act_q;
  logic [NUM_SRC-1:0] next_irq_act;
  logic [NUM_SRC-1:0] next_fiq_act;
  logic [31:0] irq_vec_q;
  logic [31:0] fiq_vec_q;
  logic [31:0] next_irq_vec;
  logic [31:0] next_fiq_vec;
  vic_rsp_t cp_rsp_q;
  vic_rsp_t mm_rsp_q;

  // The memory-mapped port reuses the coprocessor decode, so both views match.
  always_comb begin
    mm_req.valid = mm_valid_i;
    mm_req.write = mm_write_i;
    mm_req.grp = mm_addr_i[MM_GRP_LSB+3:MM_GRP_LSB];
    mm_req.sel = mm_addr_i[MM_SEL_LSB+3:MM_SEL_LSB];
    mm_req.wdata = mm_wdata_i;
  end

  function automatic logic wr_hit(input vic_req_t r, input logic [3:0] g,
                                  input logic [3:0] s);
    return r.valid && r.write && r.grp == g && r.sel == s;
  endfunction

  // Both ports may write in one cycle; the coprocessor write lands last.
  function automatic logic [31:0] wr_val(input logic [31:0] cur,
                                         input logic [3:0] g,
                                         input logic [3:0] s,
                                         input vic_req_t cp,
                                         input vic_req_t mm);
    logic [31:0] v;
    v = cur;
    if (wr_hit(mm, g, s)) begin
      v = mm.wdata;
    end
    if (wr_hit(cp, g, s)) begin
      v = cp.wdata;
    end
    return v;
  endfunction

  for (genvar w = 0; w < NW; w++) begin : g_word
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
        mask_q[w] <= RST_WORD;
      end else if (sw_reset_i) begin
        mask_q[w] <= RST_WORD;
      end else begin
        mask_q[w] <= wr_val(mask_q[w], GRP_MASK, 4'(w), cp_req_i,
                            mm_req);
      end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
        route_q[w] <= RST_WORD;
      end else if (sw_reset_i) begin
        route_q[w] <= RST_WORD;
      end else begin
        route_q[w] <= wr_val(route_q[w], GRP_ROUTE, 4'(w), cp_req_i,
                             mm_req);
      end
    end

    assign mask_all[w*SRC_PER_WORD +: SRC_PER_WORD] = mask_q[w];
    assign route_all[w*SRC_PER_WORD +: SRC_PER_WORD] = route_q[w];
  end

  for (genvar p = 0; p < NP; p++) begin : g_prio
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
        prio_q[p] <= RST_WORD;
      end else if (sw_reset_i) begin
        prio_q[p] <= RST_WORD;
      end else begin
        prio_q[p] <= wr_val(prio_q[p], GRP_PRIO, 4'(p), cp_req_i,
                            mm_req);
      end
    end

    assign prio_all[p*DATA_W +: DATA_W] = prio_q[p];
  end

  // Region base and size.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      base_q <= RST_WORD;
      size_q <= RST_SIZE;
    end else if (sw_reset_i) begin
      base_q <= RST_WORD;
      size_q <= RST_SIZE;
    end else begin
      base_q <= wr_val(base_q, GRP_CTRL, SEL_BASE, cp_req_i,
                       mm_req);
      size_q <= SIZE_W'(wr_val({28'h0, size_q}, GRP_CTRL, SEL_SIZE,
                               cp_req_i, mm_req));
    end
  end

  // A source counts only while pending and unmasked; steering splits it.
  assign next_irq_act = pend_q & mask_all & ~route_all;
  assign next_fiq_act = pend_q & mask_all & route_all;

  // Requests are levels: nothing latches, so a bit falls with its request.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      pend_q <= '0;
      irq_act_q <= '0;
      fiq_act_q <= '0;
    end else if (sw_reset_i) begin
      pend_q <= '0;
      irq_act_q <= '0;
      fiq_act_q <= '0;
    end else begin
      pend_q <= src_i;
      irq_act_q <= next_irq_act;
      fiq_act_q <= next_fiq_act;
    end
  end

  assign irq_o = |irq_act_q;
  assign fiq_o = |fiq_act_q;

  // Scanning downward with >= lets the lowest index win a tie.
  function automatic logic [IDX_W:0] pick(input logic [NUM_SRC-1:0] act,
                                          input logic [PRIO_W*NUM_SRC-1:0] pr);
    logic found;
    logic [PRIO_W-1:0] best;
    logic [IDX_W-1:0] idx;
    found = 1'b0;
    best = '0;
    idx = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (act[i] && (!found || pr[PRIO_W*i +: PRIO_W] >= best)) begin
        found = 1'b1;
        best = pr[PRIO_W*i +: PRIO_W];
        idx = IDX_W'(i);
      end
    end
    return {found, idx};
  endfunction

  // Base bits below the region size are ignored rather than trusted.
  function automatic logic [31:0] vector(input logic [IDX_W:0] hit,
                                         input logic [31:0] base,
                                         input logic [SIZE_W-1:0] size);
    logic [31:0] keep;
    keep = ~((32'h1 << (int'(size) + REGION_SHIFT)) - 32'h1);
    if (!hit[IDX_W] || size == SIZE_OFF) begin
      return VEC_NONE;
    end
    return (base & keep) |
           (32'(hit[IDX_W-1:0]) << (int'(size) + SPACE_SHIFT));
  endfunction

  assign next_irq_vec = vector(pick(irq_act_q, prio_all), base_q, size_q);
  assign next_fiq_vec = vector(pick(fiq_act_q, prio_all), base_q, size_q);

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      irq_vec_q <= VEC_NONE;
      fiq_vec_q <= VEC_NONE;
    end else if (sw_reset_i) begin
      irq_vec_q <= VEC_NONE;
      fiq_vec_q <= VEC_NONE;
    end else begin
      irq_vec_q <= next_irq_vec;
      fiq_vec_q <= next_fiq_vec;
    end
  end

  // Opcode fields are not decoded at all; the processor keeps them zero.
  function automatic vic_rsp_t rd(input vic_req_t r);
    vic_rsp_t o;
    int s;
    o.ack = r.valid;
    o.rdata = RST_WORD;
    s = int'(r.sel);
    unique case (r.grp)
      GRP_CTRL: begin
        if (r.sel == SEL_BASE) begin
          o.rdata = base_q;
        end else if (r.sel == SEL_SIZE) begin
          o.rdata = {28'h0, size_q};
        end else if (r.sel == SEL_IRQ_VEC) begin
          o.rdata = irq_vec_q;
        end else if (r.sel == SEL_FIQ_VEC) begin
          o.rdata = fiq_vec_q;
        end
      end
      GRP_PEND: begin
        if (s < NW) begin
          o.rdata = pend_q[s*SRC_PER_WORD +: SRC_PER_WORD];
        end
      end
      GRP_MASK: begin
        if (s < NW) begin
          o.rdata = mask_q[s];
        end
      end
      GRP_ROUTE: begin
        if (s < NW) begin
          o.rdata = route_q[s];
        end
      end
      GRP_IRQ_ACT: begin
        if (s < NW) begin
          o.rdata = irq_act_q[s*SRC_PER_WORD +: SRC_PER_WORD];
        end
      end
      GRP_FIQ_ACT: begin
        if (s < NW) begin
          o.rdata = fiq_act_q[s*SRC_PER_WORD +: SRC_PER_WORD];
        end
      end
      GRP_PRIO: begin
        if (s < NP) begin
          o.rdata = prio_q[s];
        end
      end
      default: begin
        o.ack = 1'b0;
      end
    endcase
    return o;
  endfunction

  // Both ports answer one cycle after the request with registered data.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cp_rsp_q <= '0;
      mm_rsp_q <= '0;
    end else begin
      cp_rsp_q <= rd(cp_req_i);
      mm_rsp_q <= rd(mm_req);
    end
  end

  assign cp_rsp_o = cp_rsp_q;
  assign mm_rsp_o = mm_rsp_q;

  sw_reset_clear_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    sw_reset_i |=> mask_q[0] == RST_WORD && route_q[0] == RST_WORD &&
      irq_act_q == '0 && fiq_act_q == '0)
    else $error("software reset left state set");

  prio_reset_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    sw_reset_i |=> prio_all == '0)
    else $error("priority not cleared by software reset");

  irq_gating_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !sw_reset_i |=> irq_act_q == $past(next_irq_act))
    else $error("IRQ source bits do not follow mask and steering");

  fiq_gating_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !sw_reset_i ##1 !sw_reset_i |=> fiq_act_q ==
      ($past(src_i, 2) & $past(mask_all) & $past(route_all)))
    else $error("FIQ source bits do not follow pending and steering");

  level_follow_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !sw_reset_i |=> pend_q == $past(src_i))
    else $error("pending bits do not follow source levels");

  vec_none_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    irq_act_q == '0 |=> irq_vec_q == VEC_NONE)
    else $error("IRQ vector not all ones with no active source");

  vec_region_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    size_q == 4'h8 && irq_act_q != '0 && !sw_reset_i |=>
      irq_vec_q[31:16] == $past(base_q[31:16]))
    else $error("64 KB region vector does not keep upper base bits");

  tie_low_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    irq_act_q[0] && prio_all == '0 && size_q == 4'h1 && !sw_reset_i |=>
      irq_vec_q[8:0] == 9'h0)
    else $error("tie at equal priority not won by source zero");

  timer_group_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    cp_req_i.valid && cp_req_i.grp == GRP_TIMER |=> !cp_rsp_o.ack)
    else $error("controller answered the timer group");

  mask_write_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    wr_hit(cp_req_i, GRP_MASK, 4'h0) && !sw_reset_i |=>
      mask_q[0] == $past(cp_req_i.wdata))
    else $error("mask register 0 did not take written value");

  pend_read_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    cp_req_i.valid && !cp_req_i.write && cp_req_i.grp == GRP_PEND &&
      cp_req_i.sel == 4'h0 |=> cp_rsp_o.ack &&
      cp_rsp_o.rdata == $past(pend_q[31:0]))
    else $error("pending register 0 read returned wrong data");

  mm_timer_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    mm_req.valid && mm_req.grp == GRP_TIMER |=> !mm_rsp_o.ack)
    else $error("memory port answered the timer group");

  mm_ack_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    mm_req.valid && mm_req.grp >= GRP_CTRL && mm_req.grp <= GRP_PRIO |=>
      mm_rsp_o.ack)
    else $error("memory port did not answer a mapped group");

  fiq_none_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    fiq_act_q == '0 |=> fiq_vec_q == VEC_NONE)
    else $error("FIQ vector not all ones with no active source");

  size_off_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    size_q == SIZE_OFF |=>
      irq_vec_q == VEC_NONE && fiq_vec_q == VEC_NONE)
    else $error("disabled region still produced a vector");

  route_reset_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    sw_reset_i |=> route_all == '0 && mask_all == '0 &&
      base_q == RST_WORD && size_q == RST_SIZE)
    else $error("software reset left steering, mask or region set");

  reserved_read_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    cp_req_i.valid && !cp_req_i.write && cp_req_i.grp == GRP_CTRL &&
      cp_req_i.sel == 4'h1 |=> cp_rsp_o.rdata == RST_WORD)
    else $error("reserved control select did not read zero");

  route_excl_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (irq_act_q & fiq_act_q) == '0)
    else $error("a source shows as both IRQ and FIQ");

  mm_write_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    wr_hit(mm_req, GRP_ROUTE, 4'h0) && !wr_hit(cp_req_i, GRP_ROUTE, 4'h0) &&
      !sw_reset_i |=> route_q[0] == $past(mm_req.wdata))
    else $error("steering register 0 missed a memory-mapped write");

endmodule

// File: dv/vic_src_model.sv
// Peripheral request levels as the interrupt sources present them.
`timescale 1ns/1ps
module vic_src_model (
  // Clock
  input wire logic clk_sys_i,
  // Requested levels from the bench and levels seen by the controller
  input wire logic [127:0] want_i,
  output logic [127:0] src_o
);
  initial src_o = '0;
  // A request stays up until the peripheral itself withdraws it.
  always @(negedge clk_sys_i) begin
    src_o <= want_i;
  end
  // The port carries no opcode fields, so they are zero by design.
endmodule

// File: dv/testbench.sv
// Self-checking bench for the interrupt controller register block.
`timescale 1ns/1ps
module testbench;
  import vic_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic sw_reset_i = 1'b0;
  vic_req_t cp_req = '0;
  vic_rsp_t cp_rsp;
  vic_rsp_t mm_rsp;
  logic mm_valid = 1'b0;
  logic mm_write = 1'b0;
  logic [MM_ADDR_W-1:0] mm_addr = '0;
  logic [31:0] mm_wdata = '0;
  logic [127:0] want = '0;
  logic [127:0] src;
  logic irq;
  logic fiq;
  int num_errors = 0;
  int samples_checked = 0;
  integer seed = 53575;
  logic [31:0] m_mask [4];
  logic [31:0] m_route [4];
  logic [31:0] m_prio [8];
  logic [31:0] m_base;
  logic [3:0] m_size;

  always #10 clk_sys_i = ~clk_sys_i;

  vic_src_model src_u (.clk_sys_i(clk_sys_i), .want_i(want), .src_o(src));

  vic_regs #(.NUM_SRC(128)) dut_u (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .sw_reset_i(sw_reset_i),
    .cp_req_i(cp_req), .cp_rsp_o(cp_rsp), .mm_valid_i(mm_valid),
    .mm_write_i(mm_write), .mm_addr_i(mm_addr), .mm_wdata_i(mm_wdata),
    .mm_rsp_o(mm_rsp), .src_i(src), .irq_o(irq), .fiq_o(fiq)
  );

  task automatic test_done();
    $display("Checks %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic void model_clear();
    m_base = 32'h0;
    m_size = 4'h0;
    for (int i = 0; i < 8; i++) begin
      m_prio[i] = 32'h0;
      if (i < 4) begin
        m_mask[i] = 32'h0;
        m_route[i] = 32'h0;
      end
    end
  endfunction

  // Active sources of one word, for IRQ (f = 0) or FIQ (f = 1).
  function automatic logic [31:0] act(input int w, input bit f);
    return src[w*32+:32] & m_mask[w] & (f ? m_route[w] : ~m_route[w]);
  endfunction

  function automatic logic [31:0] vec(input bit f);
    int best = -1;
    int lvl = -1;
    int p;
    logic [31:0] a;
    for (int i = 0; i < 128; i++) begin
      a = act(i / 32, f);
      if (a[i % 32]) begin
        p = int'((m_prio[i / 16] >> (2 * (i % 16))) & 32'h3);
        if (p > lvl) begin
          lvl = p;
          best = i;
        end
      end
    end
    if (best < 0 || m_size == 4'h0) return 32'hFFFF_FFFF;
    return (m_base & ~((32'h1 << (m_size + 8)) - 32'h1)) |
      (32'(best) << (m_size + 1));
  endfunction

  function automatic logic [31:0] exp_rd(input int g, input int s);
    case (g)
      2: begin
        if (s == 0) return m_base;
        if (s == 2) return {28'h0, m_size};
        if (s == 3) return vec(1'b0);
        if (s == 4) return vec(1'b1);
      end
      3: if (s < 4) return src[s*32+:32];
      4: if (s < 4) return m_mask[s];
      5: if (s < 4) return m_route[s];
      6: if (s < 4) return act(s, 1'b0);
      7: if (s < 4) return act(s, 1'b1);
      8: if (s < 8) return m_prio[s];
      default: return 32'h0;
    endcase
    return 32'h0;
  endfunction

  task automatic acc(input bit mm, input bit w, input int g, input int s,
      input logic [31:0] d, output vic_rsp_t r);
    @(negedge clk_sys_i);
    if (mm) begin
      mm_valid = 1'b1;
      mm_write = w;
      mm_addr = {4'(g), 4'(s), 2'b00};
      mm_wdata = d;
    end else begin
      cp_req = '{valid: 1'b1, write: w, grp: 4'(g), sel: 4'(s), wdata: d};
    end
    @(negedge clk_sys_i);
    mm_valid = 1'b0;
    cp_req.valid = 1'b0;
    r = mm ? mm_rsp : cp_rsp;
  endtask

  task automatic wr(input bit mm, input int g, input int s,
      input logic [31:0] d);
    vic_rsp_t r;
    acc(mm, 1'b1, g, s, d, r);
    chk({31'h0, r.ack}, 32'h1);
    if (g == 2 && s == 0) m_base = d;
    if (g == 2 && s == 2) m_size = d[3:0];
    if (g == 4 && s < 4) m_mask[s] = d;
    if (g == 5 && s < 4) m_route[s] = d;
    if (g == 8 && s < 8) m_prio[s] = d;
  endtask

  // Reads selects 0 to 9 of groups 2 to 8, plus groups that must stay silent.
  task automatic rd_all();
    vic_rsp_t r;
    for (int g = 0; g < 10; g++) begin
      for (int s = 0; s < 10; s++) begin
        acc($random(seed) & 1, 1'b0, g, s, 32'h0, r);
        chk({31'h0, r.ack}, {31'h0, g >= 2 && g <= 8});
        if (r.ack === 1'b1) chk(r.rdata, exp_rd(g, s));
      end
    end
    chk({30'h0, fiq, irq}, {30'h0, |{act(0, 1), act(1, 1), act(2, 1),
      act(3, 1)}, |{act(0, 0), act(1, 0), act(2, 0), act(3, 0)}});
  endtask

  initial begin
    model_clear();
    repeat (6) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    reset_i = 1'b0;
    rd_all();
    for (int it = 0; it < 40; it++) begin
      for (int s = 0; s < 8; s++) begin
        if (s < 4) wr($random(seed) & 1, 4, s, $random(seed));
        if (s < 4) wr($random(seed) & 1, 5, s, $random(seed));
        wr($random(seed) & 1, 8, s, $random(seed));
      end
      wr($random(seed) & 1, 2, 0, $random(seed));
      wr($random(seed) & 1, 2, 2, $random(seed));
      wr($random(seed) & 1, 2 + it % 7, 3 + it % 2, $random(seed));
      want = {$random(seed), $random(seed), $random(seed), $random(seed)};
      if (it % 4 == 3) want = '0;
      repeat (5) @(negedge clk_sys_i);
      rd_all();
    end
    want = {$random(seed), $random(seed), $random(seed), $random(seed)};
    repeat (5) @(negedge clk_sys_i);
    want = '0;
    repeat (5) @(negedge clk_sys_i);
    sw_reset_i = 1'b1;
    @(negedge clk_sys_i);
    sw_reset_i = 1'b0;
    model_clear();
    rd_all();
    test_done();
  end

  // Watchdog sized well above the roughly ten thousand cycles of the tests.
  initial begin
    #(20 * 60000);
    num_errors++;
    $display("ERROR at %0t: watchdog got %h expected %h", $time, 1'b1, 1'b0);
    test_done();
  end
endmodule
